// ### src/swk_sleep_seq.sv
// sleep entry and interrupt wake-up sequencer with apb registers
// assumes synchronous apb master, sources hold flags until cleared by software
//
// The placing of the registers and the APB slave port were left to the implementer.
module swk_sleep_seq #(
    parameter int unsigned N = swk_pkg::SRC_N
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt sources
    input wire logic [N-1:0] irq_flag,
    // core side
    output logic global_irq_enable,
    output logic core_halt,
    output logic wake_pulse,
    output logic watchdog_clear
);
    typedef enum logic [2:0] {
        S_RUN = 3'b001,
        S_EXEC = 3'b010,
        S_SLEEP = 3'b100
    } swk_state_t;

    swk_state_t st_r, st_nxt;
    swk_pkg::swk_stat_t stat_r, stat_nxt;
    logic irq_en_r, irq_en_nxt;
    logic [N-1:0] ien_r, ien_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic slverr_r, slverr_nxt;
    logic wake_r, wake_nxt;
    logic wdclr_r, wdclr_nxt;
    logic wake_cond;
    logic wr_acc, rd_acc, sleep_cmd, clrwd_cmd;
    logic wr_setup, rd_setup;

    swk_wake_or #(.N(N)) u_or (
        .flag(irq_flag),
        .enable(ien_r),
        .wake(wake_cond)
    );

    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;
    assign wr_setup = psel & ~penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign sleep_cmd = wr_acc & (paddr == swk_pkg::OFS_CMD) & pwdata[swk_pkg::CMD_SLEEP_BIT];
    assign clrwd_cmd = wr_acc & (paddr == swk_pkg::OFS_CMD) & pwdata[swk_pkg::CMD_CLRWD_BIT];

    always_comb
    begin
        st_nxt = st_r;
        stat_nxt = stat_r;
        irq_en_nxt = irq_en_r;
        ien_nxt = ien_r;
        wake_nxt = 1'b0;
        wdclr_nxt = clrwd_cmd;
        prdata_nxt = 32'h0000_0000;
        slverr_nxt = 1'b0;
        // writes land at the access edge
        if (wr_acc)
        begin
            unique case (paddr)
                swk_pkg::OFS_CTRL: irq_en_nxt = pwdata[swk_pkg::CTRL_IRQ_EN_BIT];
                swk_pkg::OFS_IEN: ien_nxt = pwdata[N-1:0];
                default: ;
            endcase
        end
        // answer loaded in the setup cycle so it stands at the zero-wait access edge
        if (wr_setup)
        begin
            unique case (paddr)
                swk_pkg::OFS_CTRL, swk_pkg::OFS_IEN, swk_pkg::OFS_CMD: ;
                default: slverr_nxt = 1'b1;
            endcase
        end
        if (rd_setup)
        begin
            unique case (paddr)
                swk_pkg::OFS_CTRL: prdata_nxt[swk_pkg::CTRL_IRQ_EN_BIT] = irq_en_r;
                swk_pkg::OFS_STAT:
                begin
                    prdata_nxt[swk_pkg::STAT_PWRDN_BIT] = stat_r.pwrdn;
                    prdata_nxt[swk_pkg::STAT_TMOUT_BIT] = stat_r.tmout;
                    prdata_nxt[swk_pkg::STAT_ASLEEP_BIT] = stat_r.asleep;
                    prdata_nxt[swk_pkg::STAT_NOP_BIT] = stat_r.last_nop;
                    prdata_nxt[swk_pkg::STAT_WAKE_BIT] = wake_cond;
                end
                swk_pkg::OFS_IEN: prdata_nxt[N-1:0] = ien_r;
                swk_pkg::OFS_IFLAG: prdata_nxt[N-1:0] = irq_flag;
                swk_pkg::OFS_CMD: ;
                default: slverr_nxt = 1'b1;
            endcase
        end
        unique case (st_r)
            S_RUN:
            begin
                if (sleep_cmd)
                begin
                    if (wake_cond)
                    begin
                        stat_nxt.last_nop = 1'b1;
                    end
                    else
                    begin
                        st_nxt = S_EXEC;
                        stat_nxt.last_nop = 1'b0;
                    end
                end
            end
            S_EXEC:
            begin
                // finish the sleep in full; a late wake condition no longer cancels it
                stat_nxt.pwrdn = 1'b0;
                stat_nxt.tmout = 1'b1;
                wdclr_nxt = 1'b1;
                if (wake_cond)
                begin
                    st_nxt = S_RUN;
                    wake_nxt = 1'b1;
                end
                else
                begin
                    st_nxt = S_SLEEP;
                    stat_nxt.asleep = 1'b1;
                end
            end
            S_SLEEP:
            begin
                if (wake_cond)
                begin
                    st_nxt = S_RUN;
                    wake_nxt = 1'b1;
                    stat_nxt.asleep = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= S_RUN;
            stat_r <= '{pwrdn: swk_pkg::RST_PWRDN, tmout: swk_pkg::RST_TMOUT, asleep: 1'b0, last_nop: 1'b0};
            irq_en_r <= swk_pkg::RST_IRQ_EN;
            ien_r <= '0;
            prdata_r <= 32'h0000_0000;
            slverr_r <= 1'b0;
            wake_r <= 1'b0;
            wdclr_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            stat_r <= stat_nxt;
            irq_en_r <= irq_en_nxt;
            ien_r <= ien_nxt;
            prdata_r <= prdata_nxt;
            slverr_r <= slverr_nxt;
            wake_r <= wake_nxt;
            wdclr_r <= wdclr_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pslverr = slverr_r;
    assign pready = 1'b1;
    assign global_irq_enable = irq_en_r;
    assign core_halt = stat_r.asleep;
    assign wake_pulse = wake_r;
    assign watchdog_clear = wdclr_r;

    // prdata and pslverr are loaded in the setup cycle, so with pready tied high they stand at the access edge

    nop_keeps_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == S_RUN && sleep_cmd && wake_cond)
        |=> (stat_r.pwrdn == $past(stat_r.pwrdn) && st_r == S_RUN && (!wdclr_r || $past(clrwd_cmd))))
        else $error("no-op sleep changed power-down or watchdog");
    nop_no_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == S_RUN && sleep_cmd && wake_cond) |=> ##1 !core_halt)
        else $error("no-op sleep halted the core");
    sleep_enters_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == S_RUN && sleep_cmd && !wake_cond)
        |=> st_r == S_EXEC ##1 (!stat_r.pwrdn && stat_r.tmout && wdclr_r))
        else $error("sleep did not clear power-down, set time-out and clear watchdog");
    late_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == S_EXEC && wake_cond) |=> (st_r == S_RUN && wake_pulse && !stat_r.pwrdn))
        else $error("late wake did not complete sleep then wake");
    asleep_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r == S_SLEEP && wake_cond) |=> (!core_halt && wake_pulse))
        else $error("wake condition did not end power-down");
    enable_free_a: assert property (@(posedge pclk) disable iff (!presetn)
        (core_halt && wake_cond && !global_irq_enable) |=> !core_halt)
        else $error("wake-up depended on global enable");
    wake_or_a: assert property (@(posedge pclk) disable iff (!presetn)
        wake_cond == |(irq_flag & ien_r))
        else $error("wake condition not flag and enable");
    pwrdn_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(stat_r.pwrdn) |-> $past(st_r) == S_EXEC)
        else $error("power-down flag cleared outside a sleep");
    pend_view_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_setup && paddr == swk_pkg::OFS_STAT) |=> prdata[swk_pkg::STAT_WAKE_BIT] == $past(wake_cond))
        else $error("pending wake not reported");
    iflag_view_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_acc && paddr == swk_pkg::OFS_IFLAG) |-> prdata[N-1:0] == $past(irq_flag))
        else $error("flag read did not stand at the access edge");
    halt_after_exec_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(core_halt) |-> $past(st_r) == S_EXEC)
        else $error("core halted without a completed sleep");
    wdclr_source_a: assert property (@(posedge pclk) disable iff (!presetn)
        watchdog_clear |-> ($past(clrwd_cmd) || $past(st_r) == S_EXEC))
        else $error("watchdog cleared without command or sleep");
    wake_single_a: assert property (@(posedge pclk) disable iff (!presetn)
        wake_pulse |=> !wake_pulse)
        else $error("wake pulse longer than one cycle");
endmodule // swk_sleep_seq

// ### src/swk_pkg.sv
// package for the sleep and interrupt wake-up sequencer
// assumes one apb clock domain, with the core and the interrupt sources on the same clock
package swk_pkg;
    localparam int unsigned SRC_N = 14;
    localparam int unsigned SLEEP_EXEC_CYC = 1;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STAT = 12'h004;
    localparam logic [11:0] OFS_IEN = 12'h008;
    localparam logic [11:0] OFS_IFLAG = 12'h00C;
    localparam logic [11:0] OFS_CMD = 12'h010;
    localparam int unsigned CTRL_IRQ_EN_BIT = 0;
    localparam int unsigned STAT_PWRDN_BIT = 0;
    localparam int unsigned STAT_TMOUT_BIT = 1;
    localparam int unsigned STAT_ASLEEP_BIT = 2;
    localparam int unsigned STAT_NOP_BIT = 3;
    localparam int unsigned STAT_WAKE_BIT = 4;
    localparam int unsigned CMD_SLEEP_BIT = 0;
    localparam int unsigned CMD_CLRWD_BIT = 1;
    localparam logic RST_PWRDN = 1'b1;
    localparam logic RST_TMOUT = 1'b1;
    localparam logic RST_IRQ_EN = 1'b0;

    typedef struct packed {
        logic pwrdn;
        logic tmout;
        logic asleep;
        logic last_nop;
    } swk_stat_t;
endpackage

// ### src/swk_wake_or.sv
// wake condition reduction over all interrupt sources
// assumes flags and enables are synchronous to pclk
module swk_wake_or #(
    parameter int unsigned N = swk_pkg::SRC_N
) (
    // sources
    input wire logic [N-1:0] flag,
    input wire logic [N-1:0] enable,
    // result
    output logic wake
);
    logic [N-1:0] hit;
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_src
            assign hit[g] = flag[g] & enable[g];
        end
    endgenerate
    assign wake = |hit;
endmodule // swk_wake_or

// ### tb/swk_irq_src.sv
// interrupt source model: level flags set and cleared on request
// assumes requests change just after a rising pclk edge
module swk_irq_src #(
    parameter int unsigned N = swk_pkg::SRC_N
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // requests
    input wire logic [N-1:0] set_mask,
    input wire logic [N-1:0] clr_mask,
    // flags
    output logic [N-1:0] irq_flag
);
    timeunit 1ns;
    timeprecision 100ps;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_flag <= '0;
        else
            irq_flag <= (irq_flag & ~clr_mask) | set_mask;
    end
endmodule // swk_irq_src

// ### tb/swk_sleep_seq_tb.sv
// self-checking bench for the sleep and wake-up sequencer
// assumes swk_pkg and the source model are compiled first
module swk_sleep_seq_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned N = swk_pkg::SRC_N;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, seen;
    logic global_irq_enable, core_halt, wake_pulse, watchdog_clear;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [N-1:0] set_m, clr_m, irq_flag, en;
    int n_errors, n_compared, n_wdc, w0, i;
    int seed = 41;
    swk_sleep_seq #(.N(N)) i_swk_sleep_seq (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq_flag, .global_irq_enable, .core_halt, .wake_pulse, .watchdog_clear);
    swk_irq_src #(.N(N)) i_swk_irq_src (.pclk, .presetn, .set_mask(set_m), .clr_mask(clr_m), .irq_flag);
    function automatic logic wake_exp(input logic [N-1:0] f, e);
        return |(f & e);
    endfunction
    function automatic logic [31:0] stat_exp(input logic pwr, tmo, slp, nop);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[swk_pkg::STAT_PWRDN_BIT] = pwr;
        v[swk_pkg::STAT_TMOUT_BIT] = tmo;
        v[swk_pkg::STAT_ASLEEP_BIT] = slp;
        v[swk_pkg::STAT_NOP_BIT] = nop;
        return v;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic src(input logic [N-1:0] s, c);
        set_m <= s;
        clr_m <= c;
        @(posedge pclk);
        set_m <= '0;
        clr_m <= '0;
        @(posedge pclk);
    endtask
    task automatic wait_hi(input logic w);
        seen = 1'b0;
        repeat (10)
        begin
            @(posedge pclk);
            if ((w ? wake_pulse : core_halt) === 1'b1)
                seen = 1'b1;
        end
        @(posedge pclk);
    endtask
    task automatic final_report;
        if (n_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        pclk = 1'b0;
        forever
            #12.5 pclk = ~pclk;
    end
    always @(posedge pclk)
        if (watchdog_clear === 1'b1)
            n_wdc <= n_wdc + 1;
    initial
    begin
        #100us;
        n_errors++;
        final_report;
    end
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, set_m, clr_m} = '0;
        for (int it = 0; it < 3; it++)
        begin
            presetn <= 1'b0;
            repeat (6)
                @(posedge pclk);
            presetn <= 1'b1;
            @(posedge pclk);
            chk("irq_en_rst", 32'(swk_pkg::RST_IRQ_EN), 32'(global_irq_enable));
            apb(1'b0, swk_pkg::OFS_STAT, 32'h0);
            chk("stat_rst", stat_exp(swk_pkg::RST_PWRDN, swk_pkg::RST_TMOUT, 1'b0, 1'b0), rd & 32'hF);
            i = $unsigned($random(seed)) % N;
            en = N'($random(seed)) | (N'(1) << i);
            apb(1'b1, swk_pkg::OFS_IEN, 32'(en));
            // sleep with an enabled flag already pending
            src(N'(1) << i, '1);
            apb(1'b0, swk_pkg::OFS_IFLAG, 32'h0);
            chk("iflag", 32'(N'(1) << i), rd);
            apb(1'b0, swk_pkg::OFS_STAT, 32'h0);
            chk("pending", 32'(wake_exp(N'(1) << i, en)), 32'(rd[swk_pkg::STAT_WAKE_BIT]));
            w0 = n_wdc;
            apb(1'b1, swk_pkg::OFS_CMD, 32'h1);
            wait_hi(1'b0);
            chk("halt_nop", 32'h0, 32'(seen));
            apb(1'b0, swk_pkg::OFS_STAT, 32'h0);
            chk("stat_nop", stat_exp(swk_pkg::RST_PWRDN, swk_pkg::RST_TMOUT, 1'b0, 1'b1), rd & 32'hF);
            chk("wdc_nop", 32'h0, 32'(n_wdc - w0));
            // real sleep with only masked flags
            src(~en & N'($random(seed)), '1);
            w0 = n_wdc;
            apb(1'b1, swk_pkg::OFS_CMD, 32'h2);
            apb(1'b1, swk_pkg::OFS_CMD, 32'h1);
            wait_hi(1'b0);
            chk("halt", 32'h1, 32'(seen));
            apb(1'b0, swk_pkg::OFS_STAT, 32'h0);
            chk("stat_sleep", stat_exp(1'b0, 1'b1, 1'b1, 1'b0), rd & 32'h17);
            chk("wdc_sleep", 32'h2, 32'(n_wdc - w0));
            set_m <= N'(1) << i;
            wait_hi(1'b1);
            chk("wake", 32'h1, 32'(seen));
            chk("halt_end", 32'h0, 32'(core_halt));
            // flag raised while the sleep is still executing
            src('0, '1);
            w0 = n_wdc;
            fork
                apb(1'b1, swk_pkg::OFS_CMD, 32'h1);
                begin
                    @(posedge pclk);
                    set_m <= N'(1) << i;
                end
            join
            wait_hi(1'b1);
            chk("wake_exec", 32'h1, 32'(seen));
            chk("halt_exec", 32'h0, 32'(core_halt));
            chk("wdc_exec", 32'h1, 32'(n_wdc - w0));
            apb(1'b0, swk_pkg::OFS_STAT, 32'h0);
            chk("stat_exec", stat_exp(1'b0, 1'b1, 1'b0, 1'b0), rd & 32'hF);
            set_m <= '0;
        end
        apb(1'b1, swk_pkg::OFS_CTRL, 32'h1 << swk_pkg::CTRL_IRQ_EN_BIT);
        apb(1'b0, swk_pkg::OFS_CTRL, 32'h0);
        chk("irq_en", 32'h1 << swk_pkg::CTRL_IRQ_EN_BIT, rd);
        chk("irq_en_pin", 32'h1, 32'(global_irq_enable));
        apb(1'b0, 12'hFF0, 32'h0);
        chk("slverr", 32'h1, 32'(seen));
        final_report;
    end
endmodule // swk_sleep_seq_tb
